// ==== bench/plane_mem_model.sv ====
// Four-plane frame memory model behind the plane ports
`timescale 1ns/1ps
module plane_mem_model (
   input wire logic mclk,
   input wire logic [27:0] plane_raddr,
   input wire vga_planar_pkg::plane_write_t plane_wr,
   output logic [31:0] plane_rdata
);
   import vga_planar_pkg::*;
   logic [31:0] mem_q [256];
   initial begin
      foreach (mem_q[i]) mem_q[i] = 32'h0;
   end
   // Read data follows the address within the same cycle
   assign plane_rdata = mem_q[plane_raddr[7:0]];
   always @(posedge mclk) begin
      if (plane_wr.we) begin
         for (int p = 0; p < 4; p++) begin
            if (plane_wr.en[p]) begin
               mem_q[plane_wr.addr[7:0]][8*p +: 8] <= plane_wr.data[8*p +: 8];
            end
         end
      end
   end
endmodule : plane_mem_model

// ==== bench/vga_planar_memory_access_test.sv ====
// Self-checking testbench of the planar memory access block
`timescale 1ns/1ps
module vga_planar_memory_access_test;
   import vga_planar_pkg::*;
   logic mclk = 0, rst = 1, io_wr = 0, io_rd = 0, mem_enable = 1, ram_enable = 1, chain4 = 0;
   logic cpu_hit, cpu_rvalid, graphics_mode;
   logic [7:0] io_index = 0, io_wdata = 0, io_rdata, cpu_rdata, rv, d, bm, c, inc, e, a, b;
   logic [2:0] r;
   logic [1:0] wm, fn;
   logic [31:0] plane_rdata, lat;
   logic [31:0] exp_mem [256];
   logic [27:0] plane_raddr;
   cpu_access_t cpu = '0;
   plane_write_t plane_wr;
   logic [7:0] exp_q [$];
   int n_errors = 0, samples_checked = 0;
   integer seed = 32'h8f7530ee;

   always #5 mclk = ~mclk;

   vga_planar_memory_access u_dut (.mclk(mclk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_index(io_index),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_enable(mem_enable), .ram_enable(ram_enable), .chain4(chain4),
      .plane_write_mask(4'hF), .cpu(cpu), .cpu_hit(cpu_hit), .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata),
      .plane_rdata(plane_rdata), .plane_wr(plane_wr), .plane_raddr(plane_raddr), .graphics_mode(graphics_mode));
   plane_mem_model u_mem (.mclk(mclk), .plane_raddr(plane_raddr), .plane_wr(plane_wr), .plane_rdata(plane_rdata));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
      @(negedge mclk);
      io_wr = 1;
      io_index = idx;
      io_wdata = val;
      @(negedge mclk);
      io_wr = 0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] idx, output logic [7:0] val);
      @(negedge mclk);
      io_rd = 1;
      io_index = idx;
      @(negedge mclk);
      io_rd = 0;
      val = io_rdata;
   endtask : reg_rd

   // Read results are queued here and matched by the monitor
   task automatic cpu_acc(input logic w, input logic [19:0] ad, input logic [7:0] dd, input logic hit,
      input logic [7:0] ex);
      @(negedge mclk);
      if (hit && !w) exp_q.push_back(ex);
      cpu = {1'b1, w, ad, dd};
      @(negedge mclk);
      cpu.req = 0;
      check(32'(cpu_hit), 32'(hit), "cpu_hit");
      repeat (2) @(negedge mclk);
   endtask : cpu_acc

   function automatic logic [7:0] exp_byte(input logic [1:0] wm, input logic [7:0] d, input logic [2:0] r,
      input logic [1:0] fn, input logic [7:0] bm, input logic [7:0] e, input int p, input logic [7:0] l);
      logic [7:0] v;
      logic [7:0] m;
      v = (d >> r) | (d << (4'd8 - r));
      m = wm == 2'd3 ? d & bm : bm;
      if ((wm == 2'd0 && e[p]) || wm == 2'd3) v = {8{e[4+p]}};
      if (wm == 2'd2) v = {8{d[p]}};
      if (wm == 2'd1) return l;
      case (fn)
         2'd1: v = v & l;
         2'd2: v = v | l;
         2'd3: v = v ^ l;
         default: ;
      endcase
      return (v & m) | (l & ~m);
   endfunction : exp_byte

   always @(negedge mclk) begin
      if (cpu_rvalid === 1'b1) begin
         check(32'(cpu_rdata), exp_q.size() > 0 ? 32'(exp_q.pop_front()) : 32'hX, "cpu_rdata");
      end
   end

   initial begin
      #100000;
      n_errors++;
      results();
   end

   initial begin
      foreach (exp_mem[i]) exp_mem[i] = 32'h0;
      repeat (8) @(negedge mclk);
      rst = 0;
      reg_rd(IDX_PAGE_MAPPING, rv);
      check(32'(rv), 32'(PAGE_MAPPING_RESET), "page_address_mapping");
      reg_wr(IDX_MAP_CHAIN, 8'hFF);
      reg_rd(IDX_MAP_CHAIN, rv);
      check(32'(rv), 32'h0F, "memory_map_and_chain_control");
      check(32'(graphics_mode), 32'h1, "graphics_mode");
      // No plane included: compare result is all ones
      reg_wr(IDX_COMPARE_INCLUDE, 8'h00);
      reg_wr(IDX_MODE_CONTROL, 8'h08);
      for (int m = 0; m < 4; m++) begin
         reg_wr(IDX_MAP_CHAIN, {4'h0, 2'(m), 2'b01});
         for (int k = 0; k < 3; k++) begin
            cpu_acc(0, k == 0 ? APERTURE_A0000 : k == 1 ? APERTURE_B0000 : APERTURE_B8000, 0,
               m == 0 || m == k + 1, 8'hFF);
         end
      end
      reg_wr(IDX_MAP_CHAIN, 8'h05);
      mem_enable = 0;
      cpu_acc(0, APERTURE_A0000, 0, 0, 0);
      mem_enable = 1;
      ram_enable = 0;
      cpu_acc(0, APERTURE_AFFFF, 0, 0, 0);
      ram_enable = 1;
      $display("test registers and aperture done");
      for (int it = 0; it < 16; it++) begin
         wm = it[1:0];
         fn = it[3:2];
         d = 8'($random(seed));
         bm = 8'($random(seed));
         e = 8'($random(seed));
         c = 8'($random(seed));
         inc = 8'($random(seed));
         a = 8'($random(seed));
         b = a + 8'h01;
         r = wm == 2'd3 ? 3'd0 : c[6:4];
         reg_wr(IDX_ROTATE_LOGIC, {3'h0, fn, r});
         reg_wr(IDX_FILL_VALUE, {4'h0, e[7:4]});
         reg_wr(IDX_FILL_ENABLE, {4'h0, e[3:0]});
         reg_wr(IDX_BIT_MASK, bm);
         reg_wr(IDX_MODE_CONTROL, {6'h0, wm});
         reg_wr(IDX_READ_PLANE, 8'h00);
         cpu_acc(0, APERTURE_A0000 + 20'(a), 0, 1, exp_mem[a][7:0]);
         lat = exp_mem[a];
         cpu_acc(1, APERTURE_A0000 + 20'(b), d, 1, 0);
         for (int p = 0; p < 4; p++) exp_mem[b][8*p +: 8] = exp_byte(wm, d, r, fn, bm, e, p, lat[8*p +: 8]);
         for (int p = 0; p < 4; p++) begin
            reg_wr(IDX_READ_PLANE, 8'(p));
            cpu_acc(0, APERTURE_A0000 + 20'(b), 0, 1, exp_mem[b][8*p +: 8]);
         end
         rv = 8'hFF;
         for (int p = 0; p < 4; p++) begin
            if (inc[p]) rv = rv & ~(exp_mem[b][8*p +: 8] ^ {8{c[p]}});
         end
         reg_wr(IDX_COLOR_MATCH, {4'h0, c[3:0]});
         reg_wr(IDX_COMPARE_INCLUDE, inc);
         reg_wr(IDX_MODE_CONTROL, 8'h08);
         cpu_acc(0, APERTURE_A0000 + 20'(b), 0, 1, rv);
      end
      $display("test write and read modes done");
      // Odd/even and chain-4 plane steering
      reg_wr(IDX_ROTATE_LOGIC, 8'h00);
      reg_wr(IDX_FILL_ENABLE, 8'h00);
      reg_wr(IDX_BIT_MASK, 8'hFF);
      reg_wr(IDX_MODE_CONTROL, 8'h10);
      reg_wr(IDX_READ_PLANE, 8'h00);
      cpu_acc(1, APERTURE_A0000 + 20'h00003, 8'h3C, 1, 0);
      exp_mem[2][15:8] = 8'h3C;
      exp_mem[2][31:24] = 8'h3C;
      cpu_acc(0, APERTURE_A0000 + 20'h00003, 0, 1, 8'h3C);
      check(32'(plane_raddr), 32'h2, "plane_raddr");
      cpu_acc(0, APERTURE_A0000 + 20'h00002, 0, 1, exp_mem[2][7:0]);
      chain4 = 1;
      cpu_acc(1, APERTURE_A0000 + 20'h00006, 8'h5A, 1, 0);
      exp_mem[4][23:16] = 8'h5A;
      cpu_acc(0, APERTURE_A0000 + 20'h00006, 0, 1, 8'h5A);
      chain4 = 0;
      $display("test plane addressing done");
      reg_wr(IDX_LOWER_PAGE, 8'h5C);
      reg_wr(IDX_PAGE_MAPPING, 8'hA1);
      cpu_acc(1, APERTURE_A0000 + 20'h01234, 8'h00, 1, 0);
      check(32'(plane_wr.addr), 32'hA5C1234, "plane_wr_addr");
      check(32'(exp_q.size()), 32'h0, "pending_reads");
      $display("test paging done");
      results();
   end
endmodule : vga_planar_memory_access_test

// ==== rtl/vga_planar_memory_access.sv ====
// Module: legacy planar frame-buffer access, indexed registers and page mapping
`timescale 1ns/1ps
module vga_planar_memory_access
   import vga_planar_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_index,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic mem_enable,
   input wire logic ram_enable,
   input wire logic chain4,
   input wire logic [3:0] plane_write_mask,
   input wire vga_planar_pkg::cpu_access_t cpu,
   output logic cpu_hit,
   output logic cpu_rvalid,
   output logic [7:0] cpu_rdata,
   input wire logic [31:0] plane_rdata,
   output vga_planar_pkg::plane_write_t plane_wr,
   output logic [27:0] plane_raddr,
   output logic graphics_mode
);
   import vga_planar_pkg::*;

   logic [7:0] fill_value_q, fill_enable_q, color_match_q, rotate_logic_q, read_plane_q;
   logic [7:0] mode_q, map_q, include_q, mask_q, page_map_q, lower_page_q;
   logic [31:0] latch_q;
   logic rd_pend_q;
   logic [1:0] rd_plane_q;
   logic in_aperture;
   logic hit;
   logic [15:0] off;
   logic [3:0] plane_en;
   logic [27:0] addr;
   logic [1:0] rsel;
   logic [31:0] wdata;
   logic [7:0] cmp;

   // Indexed register writes; only implemented bits store
   always_ff @(posedge mclk) begin
      if (rst) begin
         fill_value_q <= REG_RESET;
         fill_enable_q <= REG_RESET;
         color_match_q <= REG_RESET;
         rotate_logic_q <= REG_RESET;
         read_plane_q <= REG_RESET;
         mode_q <= REG_RESET;
         map_q <= REG_RESET;
         include_q <= REG_RESET;
         mask_q <= REG_RESET;
         page_map_q <= PAGE_MAPPING_RESET;
         lower_page_q <= REG_RESET;
      end else if (io_wr) begin
         unique case (io_index)
            IDX_FILL_VALUE: fill_value_q <= io_wdata & NIBBLE_WMASK;
            IDX_FILL_ENABLE: fill_enable_q <= io_wdata & NIBBLE_WMASK;
            IDX_COLOR_MATCH: color_match_q <= io_wdata & NIBBLE_WMASK;
            IDX_ROTATE_LOGIC: rotate_logic_q <= io_wdata & ROTATE_WMASK;
            IDX_READ_PLANE: read_plane_q <= io_wdata & PLANE_SEL_WMASK;
            IDX_MODE_CONTROL: mode_q <= io_wdata & MODE_WMASK;
            IDX_MAP_CHAIN: map_q <= io_wdata & MAP_WMASK;
            IDX_COMPARE_INCLUDE: include_q <= io_wdata & NIBBLE_WMASK;
            IDX_BIT_MASK: mask_q <= io_wdata;
            IDX_PAGE_MAPPING: page_map_q <= io_wdata;
            IDX_LOWER_PAGE: lower_page_q <= io_wdata;
            default: ;
         endcase
      end
   end

   // Register read-back, registered
   always_ff @(posedge mclk) begin
      if (rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         unique case (io_index)
            IDX_FILL_VALUE: io_rdata <= fill_value_q;
            IDX_FILL_ENABLE: io_rdata <= fill_enable_q;
            IDX_COLOR_MATCH: io_rdata <= color_match_q;
            IDX_ROTATE_LOGIC: io_rdata <= rotate_logic_q;
            IDX_READ_PLANE: io_rdata <= read_plane_q;
            IDX_MODE_CONTROL: io_rdata <= mode_q;
            IDX_MAP_CHAIN: io_rdata <= map_q;
            IDX_COMPARE_INCLUDE: io_rdata <= include_q;
            IDX_BIT_MASK: io_rdata <= mask_q;
            IDX_PAGE_MAPPING: io_rdata <= page_map_q;
            IDX_LOWER_PAGE: io_rdata <= lower_page_q;
            default: io_rdata <= 8'h00;
         endcase
      end
   end

   // Aperture decode
   always_comb begin
      unique case (map_q[3:2])
         2'b00: in_aperture = cpu.addr >= APERTURE_A0000 && cpu.addr <= APERTURE_BFFFF;
         2'b01: in_aperture = cpu.addr >= APERTURE_A0000 && cpu.addr <= APERTURE_AFFFF;
         2'b10: in_aperture = cpu.addr >= APERTURE_B0000 && cpu.addr <= APERTURE_B7FFF;
         2'b11: in_aperture = cpu.addr >= APERTURE_B8000 && cpu.addr <= APERTURE_BFFFF;
      endcase
      hit = cpu.req && in_aperture && mem_enable && ram_enable;
   end

   // Plane selection and internal address
   always_comb begin
      off = cpu.addr[15:0];
      plane_en = plane_write_mask;
      rsel = read_plane_q[1:0];
      addr = {12'h000, off};
      if (page_map_q[0]) begin
         addr = {page_map_q[7:4], lower_page_q, off};
      end else if (chain4) begin
         plane_en = plane_write_mask & (4'b0001 << off[1:0]);
         rsel = off[1:0];
         addr = {12'h000, off[15:2], 2'b00};
      end else if (mode_q[MODE_ODD_EVEN_BIT] || map_q[MAP_CHAIN_BIT]) begin
         plane_en = plane_write_mask & (off[0] ? 4'b1010 : 4'b0101);
         rsel = {read_plane_q[1], off[0]};
         addr = {12'h000, off[15:1], 1'b0};
      end
   end

   vga_write_datapath u_wdp (
      .cpu_data(cpu.data),
      .write_mode(mode_q[1:0]),
      .rotate_count(rotate_logic_q[2:0]),
      .logic_fn(rotate_logic_q[4:3]),
      .fill_value(fill_value_q[3:0]),
      .fill_enable(fill_enable_q[3:0]),
      .bit_mask(mask_q),
      .latches(latch_q),
      .plane_data(wdata)
   );

   // Frame-buffer write strobe, one cycle per write access
   always_ff @(posedge mclk) begin
      if (rst) begin
         plane_wr <= '0;
         plane_raddr <= '0;
         cpu_hit <= 1'b0;
      end else begin
         cpu_hit <= hit;
         plane_wr.we <= hit && cpu.wr;
         plane_wr.en <= plane_en;
         plane_wr.addr <= addr;
         plane_wr.data <= wdata;
         plane_raddr <= addr;
      end
   end

   // Reads: address issued, planes return next cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         rd_plane_q <= 2'b00;
      end else begin
         rd_pend_q <= hit && !cpu.wr;
         rd_plane_q <= rsel;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         latch_q <= 32'h0000_0000;
      end else if (rd_pend_q) begin
         latch_q <= plane_rdata;
      end
   end

   always_comb begin
      cmp = 8'hFF;
      for (int p = 0; p < 4; p++) begin
         if (include_q[p]) begin
            cmp = cmp & ~(plane_rdata[p*8 +: 8] ^ {8{color_match_q[p]}});
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cpu_rvalid <= 1'b0;
         cpu_rdata <= 8'h00;
      end else begin
         cpu_rvalid <= rd_pend_q;
         if (rd_pend_q) begin
            cpu_rdata <= mode_q[MODE_READ_BIT] ? cmp : plane_rdata[rd_plane_q*8 +: 8];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         graphics_mode <= 1'b0;
      end else begin
         graphics_mode <= map_q[MAP_GRAPHICS_BIT];
      end
   end

   a_latch_load: assert property (@(posedge mclk) disable iff (rst)
      rd_pend_q |=> latch_q == $past(plane_rdata)) else $error("latches not loaded on read");
   a_map_reserved: assert property (@(posedge mclk) disable iff (rst)
      map_q[7:4] == 4'h0) else $error("reserved mapping bits set");
   a_aperture_gate: assert property (@(posedge mclk) disable iff (rst)
      !(mem_enable && ram_enable) |=> !cpu_hit) else $error("access without enables");
   a_read_valid: assert property (@(posedge mclk) disable iff (rst)
      (hit && !cpu.wr) |-> ##2 cpu_rvalid) else $error("read answer missing");
   a_write_strobe: assert property (@(posedge mclk) disable iff (rst)
      (hit && cpu.wr) |=> plane_wr.we && plane_wr.addr == $past(addr)) else $error("write strobe wrong");
   a_odd_even: assert property (@(posedge mclk) disable iff (rst)
      (hit && !page_map_q[0] && !chain4 && mode_q[4] && cpu.addr[0]) |=> (plane_wr.en & 4'b0101) == 4'h0)
      else $error("odd address hit even plane");
   a_mode1_write: assert property (@(posedge mclk) disable iff (rst)
      (hit && cpu.wr && mode_q[1:0] == 2'b01) |=> plane_wr.data == $past(latch_q)) else $error("mode 1 data");
   a_compare_all: assert property (@(posedge mclk) disable iff (rst)
      (rd_pend_q && mode_q[3] && include_q[3:0] == 4'h0) |=> cpu_rdata == 8'hFF) else $error("compare");
endmodule : vga_planar_memory_access

// ==== rtl/vga_planar_pkg.sv ====
// Package: register indexes, field positions and types of the planar memory access block
package vga_planar_pkg;
   localparam logic [7:0] IDX_FILL_VALUE = 8'h00;
   localparam logic [7:0] IDX_FILL_ENABLE = 8'h01;
   localparam logic [7:0] IDX_COLOR_MATCH = 8'h02;
   localparam logic [7:0] IDX_ROTATE_LOGIC = 8'h03;
   localparam logic [7:0] IDX_READ_PLANE = 8'h04;
   localparam logic [7:0] IDX_MODE_CONTROL = 8'h05;
   localparam logic [7:0] IDX_MAP_CHAIN = 8'h06;
   localparam logic [7:0] IDX_COMPARE_INCLUDE = 8'h07;
   localparam logic [7:0] IDX_BIT_MASK = 8'h08;
   localparam logic [7:0] IDX_PAGE_MAPPING = 8'h10;
   localparam logic [7:0] IDX_LOWER_PAGE = 8'h11;
   localparam int MODE_ODD_EVEN_BIT = 4;
   localparam int MODE_READ_BIT = 3;
   localparam int MAP_CHAIN_BIT = 1;
   localparam int MAP_GRAPHICS_BIT = 0;
   localparam logic [7:0] PAGE_MAPPING_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MODE_WMASK = 8'h7B;
   localparam logic [7:0] MAP_WMASK = 8'h0F;
   localparam logic [7:0] NIBBLE_WMASK = 8'h0F;
   localparam logic [7:0] ROTATE_WMASK = 8'h1F;
   localparam logic [7:0] PLANE_SEL_WMASK = 8'h03;
   localparam logic [19:0] APERTURE_A0000 = 20'hA0000;
   localparam logic [19:0] APERTURE_AFFFF = 20'hAFFFF;
   localparam logic [19:0] APERTURE_B0000 = 20'hB0000;
   localparam logic [19:0] APERTURE_B7FFF = 20'hB7FFF;
   localparam logic [19:0] APERTURE_B8000 = 20'hB8000;
   localparam logic [19:0] APERTURE_BFFFF = 20'hBFFFF;

   typedef enum logic [1:0] {
      WMODE_0 = 2'b00,
      WMODE_1 = 2'b01,
      WMODE_2 = 2'b10,
      WMODE_3 = 2'b11
   } write_mode_t;

   typedef enum logic [1:0] {
      LF_PASS = 2'b00,
      LF_AND = 2'b01,
      LF_OR = 2'b10,
      LF_XOR = 2'b11
   } logic_fn_t;

   typedef struct packed {
      logic req;
      logic wr;
      logic [19:0] addr;
      logic [7:0] data;
   } cpu_access_t;

   typedef struct packed {
      logic [3:0] en;
      logic we;
      logic [27:0] addr;
      logic [31:0] data;
   } plane_write_t;
endpackage : vga_planar_pkg

// ==== rtl/vga_write_datapath.sv ====
// Module: write-mode datapath producing the four plane bytes for a CPU write
`timescale 1ns/1ps
module vga_write_datapath
   import vga_planar_pkg::*;
(
   input wire logic [7:0] cpu_data,
   input wire logic [1:0] write_mode,
   input wire logic [2:0] rotate_count,
   input wire logic [1:0] logic_fn,
   input wire logic [3:0] fill_value,
   input wire logic [3:0] fill_enable,
   input wire logic [7:0] bit_mask,
   input wire logic [31:0] latches,
   output logic [31:0] plane_data
);
   logic [7:0] rotated;
   logic [7:0] mode3_mask;

   always_comb begin
      rotated = 8'((({cpu_data, cpu_data}) >> rotate_count));
      mode3_mask = rotated & bit_mask;
   end

   function automatic logic [7:0] apply_fn(input logic [1:0] fn, input logic [7:0] d, input logic [7:0] l);
      unique case (logic_fn_t'(fn))
         LF_PASS: apply_fn = d;
         LF_AND: apply_fn = d & l;
         LF_OR: apply_fn = d | l;
         LF_XOR: apply_fn = d ^ l;
      endcase
   endfunction : apply_fn

   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_plane
         logic [7:0] lat;
         logic [7:0] src;
         logic [7:0] mask;
         always_comb begin
            lat = latches[p*8 +: 8];
            src = rotated;
            mask = bit_mask;
            unique case (write_mode_t'(write_mode))
               WMODE_0: begin
                  src = fill_enable[p] ? {8{fill_value[p]}} : rotated;
                  src = apply_fn(logic_fn, src, lat);
               end
               WMODE_1: begin
                  src = lat;
                  mask = 8'hFF;
               end
               WMODE_2: src = apply_fn(logic_fn, {8{cpu_data[p]}}, lat);
               WMODE_3: begin
                  src = apply_fn(logic_fn, {8{fill_value[p]}}, lat);
                  mask = mode3_mask;
               end
            endcase
            plane_data[p*8 +: 8] = (src & mask) | (lat & ~mask);
         end
      end
   endgenerate
endmodule : vga_write_datapath
